// File: verilog/cmf_pkg.sv
// package: register map, field positions, command codes and types of the
// comparator motion block; assumes 32-bit Avalon-MM words at byte offsets
package cmf_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CMD     = 8'h00;
  localparam logic [7:0] OFS_FBCFG   = 8'h04;
  localparam logic [7:0] OFS_CMPCFG  = 8'h08;
  localparam logic [7:0] OFS_POSLIM  = 8'h0c;
  localparam logic [7:0] OFS_NEGLIM  = 8'h10;
  localparam logic [7:0] OFS_MAXDEF  = 8'h14;
  localparam logic [7:0] OFS_PREDATA = 8'h18;
  localparam logic [7:0] OFS_CMP5    = 8'h1c;
  localparam logic [7:0] OFS_CMDPOS  = 8'h20;
  localparam logic [7:0] OFS_DEFL    = 8'h24;
  localparam logic [7:0] OFS_ERRST   = 8'h28;
  localparam logic [7:0] OFS_EVTST   = 8'h2c;
  localparam logic [7:0] OFS_MSTAT   = 8'h30;
  localparam logic [7:0] OFS_OPDATA  = 8'h34;
  localparam logic [7:0] OFS_CMP5CFG = 8'h38;
  localparam logic [7:0] OFS_EVTEN   = 8'h3c;
  // command codes
  localparam logic [7:0] CMD_DEFL_CLR  = 8'h22;
  localparam logic [7:0] CMD_PRE_NEXT  = 8'h4e;
  localparam logic [7:0] CMD_PRE_SPEED = 8'h4f;
  localparam logic [7:0] CMD_CS_START  = 8'h50;
  localparam logic [7:0] CMD_CS_START2 = 8'h51;
  localparam logic [7:0] CMD_HS_START  = 8'h52;
  localparam logic [7:0] CMD_HS_START2 = 8'h53;
  localparam int CMD_DIR_BIT = 8;
  // comparator_config fields
  localparam int C1_METH_LO = 2;
  localparam int C1_ACT_LO  = 5;
  localparam int C2_METH_LO = 10;
  localparam int C2_ACT_LO  = 13;
  localparam int C3_SEL_LO  = 16;
  localparam int C3_ACT_LO  = 21;
  localparam logic [2:0] METH_SOFTLIM = 3'b110;
  localparam logic [1:0] SEL_DEFL     = 2'b10;
  localparam logic [1:0] ACT_IMMED    = 2'b01;
  localparam logic [1:0] ACT_DECEL    = 2'b10;
  localparam logic [1:0] ACT_SPEED    = 2'b11;
  // feedback_and_terminal_config fields
  localparam int ENC_MODE_LO = 20;
  localparam int ENC_DIR_BIT = 22;
  localparam logic [1:0] ENC_X1 = 2'b00;
  localparam logic [1:0] ENC_X2 = 2'b01;
  localparam logic [1:0] ENC_X4 = 2'b10;
  // status bits
  localparam int ERR_ENC_BIT = 16;
  localparam int EVT_C3_BIT  = 10;
  localparam int EVT_C5_BIT  = 12;
  // pulse engine
  localparam logic [15:0] STOP_PERIOD = 16'h0400;
  localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;
  typedef struct packed {
    logic        valid;
    logic        is_speed;
    logic [31:0] data;
  } cmf_pre_s;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DECEL} cmf_state_e;
endpackage

// File: verilog/cmf_axis.sv
// comparator motion functions of one pulse-train axis: soft limits,
// position speed change via pre-register queue, out-of-step detection.
// assumes an Avalon-MM master on clk_sys_i; encoder pins are asynchronous.
`timescale 1ns/1ps
module cmf_axis
  import cmf_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        encoder_phase_a_i,
  input  wire logic        encoder_phase_b_i,
  output logic             pulse_o,
  output logic             dir_o,
  output logic             busy_o,
  output logic             int_n_o
);
  import cmf_pkg::*;

  // stop request kind: 0 none, 1 immediate, 2 decelerate
  function automatic logic [1:0] stop_kind(input logic [1:0] act, input logic hs);
    stop_kind = 2'd0;
    if (act == ACT_DECEL && hs) begin
      stop_kind = 2'd2;
    end else if (act == ACT_IMMED || act == ACT_DECEL) begin
      stop_kind = 2'd1;
    end
  endfunction

  // start codes: the constant-speed pair and the high-speed pair
  function automatic logic is_start(input logic [7:0] code);
    is_start = code == CMD_CS_START || code == CMD_CS_START2 ||
               code == CMD_HS_START || code == CMD_HS_START2;
  endfunction

  // one queue stage from the pending word, tagged speed change or next op
  function automatic cmf_pre_s pre_entry(input logic is_speed, input logic [31:0] word);
    pre_entry          = '0;
    pre_entry.valid    = 1'b1;
    pre_entry.is_speed = is_speed;
    pre_entry.data     = word;
  endfunction

  logic        ack_r;
  logic [31:0] rdata_r;
  logic [31:0] fbcfg_r, cmpcfg_r, poslim_r, neglim_r, maxdef_r;
  logic [31:0] predata_r, cmp5_r, opdata_r, evten_r;
  logic [1:0]  cmp5cfg_r;
  logic [31:0] pos_r, pos_nxt, defl_r;
  logic [15:0] period_r, period_nxt, remain_r, remain_nxt, tick_r;
  logic        hs_r, hs_nxt, dir_r, dir_nxt, pulse_r;
  cmf_state_e  state_r, state_nxt;
  cmf_pre_s    pre1_r, pre1_nxt, pre2_r, pre2_nxt;
  logic        ea_s1_r, ea_s2_r, ea_p_r, eb_s1_r, eb_s2_r, eb_p_r;
  logic        err_enc_r, evt_c3_r, evt_c5_r, c3_prev_r, c5_prev_r;

  // bus handshake: one wait state, so every access answers on its 2nd edge
  wire req    = avs_read_i | avs_write_i;
  wire do_wr  = avs_write_i & ack_r;
  wire do_rd  = avs_read_i & ack_r;
  wire [7:0] cmd = avs_writedata_i[7:0];
  wire cmd_wr = do_wr && avs_address_i == OFS_CMD;
  // read-clear strobes and command decodes shared by several processes
  wire rd_errst = do_rd && avs_address_i == OFS_ERRST;
  wire rd_evtst = do_rd && avs_address_i == OFS_EVTST;
  wire defl_clr = cmd_wr && cmd == CMD_DEFL_CLR;
  wire pre_conf = cmd_wr && (cmd == CMD_PRE_SPEED || cmd == CMD_PRE_NEXT);
  assign avs_waitrequest_o = req & ~ack_r;
  assign avs_readdata_o    = rdata_r;

  // configuration field decode
  wire [2:0] c1_meth = cmpcfg_r[C1_METH_LO +: 3];
  wire [1:0] c1_act  = cmpcfg_r[C1_ACT_LO +: 2];
  wire [2:0] c2_meth = cmpcfg_r[C2_METH_LO +: 3];
  wire [1:0] c2_act  = cmpcfg_r[C2_ACT_LO +: 2];
  wire [1:0] c3_sel  = cmpcfg_r[C3_SEL_LO +: 2];
  wire [1:0] c3_act  = cmpcfg_r[C3_ACT_LO +: 2];
  wire [1:0] enc_mode = fbcfg_r[ENC_MODE_LO +: 2];
  wire       enc_swap = fbcfg_r[ENC_DIR_BIT];

  // software limits compare the command position counter
  wire lim_pos = (c1_meth == METH_SOFTLIM) &&
                 ($signed(pos_r) >= $signed(poslim_r));
  wire lim_neg = (c2_meth == METH_SOFTLIM) &&
                 ($signed(pos_r) <= $signed(neglim_r));
  // only the limit ahead of the travel direction can stop the axis
  wire lim_hit = dir_r ? lim_neg : lim_pos;
  wire [1:0] lim_act = dir_r ? c2_act : c1_act;
  wire [1:0] lim_stop = lim_hit ? stop_kind(lim_act, hs_r) : 2'd0;

  // out-of-step: magnitude of deflection beyond the maximum
  wire [31:0] defl_neg = 32'h0 - defl_r;
  wire c3_cond = (c3_sel == SEL_DEFL) &&
                 (($signed(defl_r) > $signed(maxdef_r)) ||
                  ($signed(defl_neg) > $signed(maxdef_r)));
  wire [1:0] oos_stop = c3_cond ? stop_kind(c3_act, hs_r) : 2'd0;
  // comparator 5 matches the command position exactly
  wire c5_cond = (pos_r == cmp5_r);
  wire c5_rise = c5_cond & ~c5_prev_r;

  // start decode; direction comes from the command word
  wire st_cmd = cmd_wr && is_start(cmd);
  wire st_hs  = cmd == CMD_HS_START || cmd == CMD_HS_START2;
  wire st_dir = avs_writedata_i[CMD_DIR_BIT];
  // a limit already met blocks only the travel that would go further past it
  wire st_blocked = st_dir ? lim_neg : lim_pos;
  wire st_ok  = st_cmd && state_r == ST_IDLE && !st_blocked;
  wire tick   = state_r != ST_IDLE && tick_r >= period_r;
  wire done   = tick && remain_r == 16'h0001;

  // encoder phases, swapped when phase b is the counting reference
  wire ea = enc_swap ? eb_s2_r : ea_s2_r;
  wire eb = enc_swap ? ea_s2_r : eb_s2_r;
  wire ep = enc_swap ? eb_p_r : ea_p_r;
  wire bp = enc_swap ? ea_p_r : eb_p_r;
  wire ach = ea ^ ep;
  wire bch = eb ^ bp;
  wire enc_err = ach & bch;
  wire quad_up = ea ^ bp;
  logic enc_cnt, enc_up, enc_dn;

  // feedback counting per mode
  always_comb begin
    enc_up = 1'b0;
    enc_dn = 1'b0;
    enc_cnt = 1'b0;
    unique case (enc_mode)
      ENC_X1: enc_cnt = ach & ~bch & ea;
      ENC_X2: enc_cnt = ach & ~bch;
      ENC_X4: enc_cnt = ach ^ bch;
      default: begin
        enc_up = ach & ea;
        enc_dn = bch & eb;
      end
    endcase
    if (enc_cnt) begin
      enc_up = quad_up;
      enc_dn = ~quad_up;
    end
  end

  // deflection step: cmd_up and enc_dn add, cmd_dn and enc_up subtract
  wire cmd_up = pulse_r & ~dir_o;
  wire cmd_dn = pulse_r & dir_o;
  // up and down terms of one cycle may be active together; cmd_up and cmd_dn never both
  wire [31:0] defl_sub  = {{31{1'b0}}, cmd_dn} + {{31{1'b0}}, enc_up};
  wire [31:0] defl_cmb  = defl_r + {{31{1'b0}}, cmd_up} + {{31{1'b0}}, enc_dn} - defl_sub;

  // motion and queue next state
  always_comb begin
    state_nxt  = state_r;
    period_nxt = period_r;
    remain_nxt = remain_r;
    pos_nxt    = pos_r;
    hs_nxt     = hs_r;
    dir_nxt    = dir_r;
    pre1_nxt   = pre1_r;
    pre2_nxt   = pre2_r;
    if (tick) begin
      pos_nxt    = dir_r ? pos_r - 32'h1 : pos_r + 32'h1;
      remain_nxt = remain_r - 16'h1;
    end
    // speed change at the comparator 5 position
    // rising edge only, so an axis parked on the position does not fire again
    if (state_r == ST_RUN && c5_rise && cmp5cfg_r == ACT_SPEED &&
        pre1_r.valid && pre1_r.is_speed) begin
      period_nxt = pre1_r.data[15:0];
      pre1_nxt   = pre2_r;
      pre2_nxt   = '0;
    end
    // each step lengthens the period by an eighth plus one; no ramp table
    if (state_r == ST_DECEL && tick) begin
      period_nxt = period_r + (period_r >> 3) + 16'h1;
      if (period_r >= STOP_PERIOD) begin
        state_nxt = ST_IDLE;
      end
    end
    if (state_r == ST_RUN && (lim_stop == 2'd2 || oos_stop == 2'd2)) begin
      state_nxt = ST_DECEL;
    end
    // an immediate stop outranks completion; queued work then stays queued
    if (state_r != ST_IDLE && (lim_stop == 2'd1 || oos_stop == 2'd1)) begin
      state_nxt = ST_IDLE;
    end else if (done) begin
      state_nxt = ST_IDLE;
      if (pre1_r.valid && pre1_r.is_speed) begin
        pre1_nxt = '0;
        pre1_nxt.data = pre2_r.data;
        pre2_nxt = '0;
        if (pre2_r.valid && !pre2_r.is_speed) begin
          state_nxt  = ST_RUN;
          period_nxt = pre2_r.data[15:0];
          remain_nxt = pre2_r.data[31:16];
        end
      end else if (pre1_r.valid) begin
        state_nxt  = ST_RUN;
        period_nxt = pre1_r.data[15:0];
        remain_nxt = pre1_r.data[31:16];
        pre1_nxt   = pre2_r;
        pre2_nxt   = '0;
      end
    end
    if (st_ok && opdata_r[31:16] != 16'h0) begin
      state_nxt  = ST_RUN;
      period_nxt = opdata_r[15:0];
      remain_nxt = opdata_r[31:16];
      hs_nxt     = st_hs;
      dir_nxt    = st_dir;
    end
    // confirm the pending word into the first free stage
    // a third confirmation with both stages full is dropped
    if (pre_conf) begin
      if (!pre1_nxt.valid) begin
        pre1_nxt = pre_entry(cmd == CMD_PRE_SPEED, predata_r);
      end else if (!pre2_nxt.valid) begin
        pre2_nxt = pre_entry(cmd == CMD_PRE_SPEED, predata_r);
      end
    end
  end

  // read multiplexer; write-only registers read as zero
  logic [31:0] rd_mux;
  always_comb begin
    unique case (avs_address_i)
      OFS_POSLIM: rd_mux = poslim_r;
      OFS_NEGLIM: rd_mux = neglim_r;
      OFS_MAXDEF: rd_mux = maxdef_r;
      OFS_PREDATA: rd_mux = predata_r;
      OFS_CMP5: rd_mux = cmp5_r;
      OFS_CMDPOS: rd_mux = pos_r;
      OFS_DEFL: rd_mux = defl_r;
      OFS_ERRST: rd_mux = {15'h0, err_enc_r, 16'h0};
      OFS_EVTST: rd_mux = {19'h0, evt_c5_r, 1'b0, evt_c3_r, 10'h0};
      OFS_MSTAT: rd_mux = {24'h0, pre2_r.valid, pre1_r.valid, lim_neg,
                           lim_pos, hs_r, dir_r, state_r};
      OFS_OPDATA: rd_mux = opdata_r;
      OFS_CMP5CFG: rd_mux = {30'h0, cmp5cfg_r};
      OFS_EVTEN: rd_mux = evten_r;
      default: rd_mux = ZERO_WORD;
    endcase
  end

  // bus slave registers
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_r     <= 1'b0;
      rdata_r   <= ZERO_WORD;
      fbcfg_r   <= ZERO_WORD;
      cmpcfg_r  <= ZERO_WORD;
      poslim_r  <= ZERO_WORD;
      neglim_r  <= ZERO_WORD;
      maxdef_r  <= ZERO_WORD;
      predata_r <= ZERO_WORD;
      cmp5_r    <= ZERO_WORD;
      opdata_r  <= ZERO_WORD;
      evten_r   <= ZERO_WORD;
      cmp5cfg_r <= 2'b00;
    end else begin
      ack_r <= req & ~ack_r;
      // captured on the first edge so the word stands when waitrequest drops
      if (avs_read_i && !ack_r) begin
        rdata_r <= rd_mux;
      end
      if (do_wr) begin
        unique case (avs_address_i)
          OFS_FBCFG: fbcfg_r <= avs_writedata_i;
          OFS_CMPCFG: cmpcfg_r <= avs_writedata_i;
          OFS_POSLIM: poslim_r <= avs_writedata_i;
          OFS_NEGLIM: neglim_r <= avs_writedata_i;
          OFS_MAXDEF: maxdef_r <= avs_writedata_i;
          OFS_PREDATA: predata_r <= avs_writedata_i;
          OFS_CMP5: cmp5_r <= avs_writedata_i;
          OFS_OPDATA: opdata_r <= avs_writedata_i;
          OFS_CMP5CFG: cmp5cfg_r <= avs_writedata_i[1:0];
          OFS_EVTEN: evten_r <= avs_writedata_i;
          default: ;
        endcase
      end
    end
  end

  // motion engine registers
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r  <= ST_IDLE;
      period_r <= 16'h0;
      remain_r <= 16'h0;
      pos_r    <= ZERO_WORD;
      hs_r     <= 1'b0;
      dir_r    <= 1'b0;
      pre1_r   <= '0;
      pre2_r   <= '0;
      tick_r   <= 16'h0;
      pulse_r  <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      period_r <= period_nxt;
      remain_r <= remain_nxt;
      pos_r    <= pos_nxt;
      hs_r     <= hs_nxt;
      dir_r    <= dir_nxt;
      pre1_r   <= pre1_nxt;
      pre2_r   <= pre2_nxt;
      pulse_r  <= tick;
      // idle holds the count at one, so a start waits a full period
      tick_r   <= (tick || state_r == ST_IDLE) ? 16'h1 : tick_r + 16'h1;
    end
  end

  // encoder synchronisers, deflection counter and sticky flags
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ea_s1_r   <= 1'b0;
      ea_s2_r   <= 1'b0;
      ea_p_r    <= 1'b0;
      eb_s1_r   <= 1'b0;
      eb_s2_r   <= 1'b0;
      eb_p_r    <= 1'b0;
      defl_r    <= ZERO_WORD;
      err_enc_r <= 1'b0;
      evt_c3_r  <= 1'b0;
      evt_c5_r  <= 1'b0;
      c3_prev_r <= 1'b0;
      c5_prev_r <= 1'b0;
    end else begin
      // two stages tame the pins; the third keeps the last phase for edges
      ea_s1_r   <= encoder_phase_a_i;
      ea_s2_r   <= ea_s1_r;
      ea_p_r    <= ea_s2_r;
      eb_s1_r   <= encoder_phase_b_i;
      eb_s2_r   <= eb_s1_r;
      eb_p_r    <= eb_s2_r;
      c3_prev_r <= c3_cond;
      c5_prev_r <= c5_cond;
      // clear wins over everything; a count landing in that cycle is lost
      defl_r    <= defl_clr ? ZERO_WORD : defl_cmb;
      // read clears; a new event in the same cycle wins
      err_enc_r <= enc_err | (err_enc_r & ~rd_errst);
      evt_c3_r  <= (c3_cond & ~c3_prev_r) | (evt_c3_r & ~rd_evtst);
      evt_c5_r  <= c5_rise | (evt_c5_r & ~rd_evtst);
    end
  end

  // pulse and direction straight from registers; busy decoded from the state register
  assign pulse_o = pulse_r;
  assign dir_o   = dir_r;
  assign busy_o  = state_r != ST_IDLE;
  // encoder error always interrupts; comparator events only when enabled
  assign int_n_o = ~(err_enc_r | (evt_c3_r & evten_r[EVT_C3_BIT]) |
                     (evt_c5_r & evten_r[EVT_C5_BIT]));
endmodule

// File: testbench/cmf_axis_asserts.sv
// checker: bus, pulse and interrupt relations seen at the axis ports
// assumes it is bound to cmf_axis and that the bench never sets a period below 2
`timescale 1ns/1ps
module cmf_axis_asserts
  import cmf_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        encoder_phase_a_i,
  input wire logic        encoder_phase_b_i,
  input wire logic        pulse_o,
  input wire logic        dir_o,
  input wire logic        busy_o,
  input wire logic        int_n_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // a read completes at the edge where waitrequest is low
  wire rd_done = avs_read_i && !avs_waitrequest_o;
  a_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("more than one wait state");
  a_idle_nowait: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
    else $error("waitrequest without request");
  a_wo_zero: assert property (rd_done && (avs_address_i == OFS_FBCFG ||
    avs_address_i == OFS_CMPCFG) |-> avs_readdata_o == ZERO_WORD)
    else $error("write-only register read nonzero");
  a_unmapped_zero: assert property (rd_done && avs_address_i > OFS_EVTEN
    |-> avs_readdata_o == ZERO_WORD) else $error("unmapped read nonzero");
  a_rdata_hold: assert property (!avs_read_i |=> $stable(avs_readdata_o))
    else $error("read data moved without a read");
  a_err_int: assert property (rd_done && avs_address_i == OFS_ERRST &&
    avs_readdata_o[ERR_ENC_BIT] |-> !int_n_o) else $error("encoder error without interrupt");
  a_pulse_short: assert property (pulse_o |=> !pulse_o) else $error("pulse wider than a cycle");
  a_pulse_busy: assert property (pulse_o |-> busy_o || $past(busy_o))
    else $error("pulse while idle");
  // main scenarios reached
  c_pulse: cover property (pulse_o);
  c_int: cover property (!int_n_o);
  c_defl_read: cover property (rd_done && avs_address_i == OFS_DEFL);
endmodule

// File: testbench/cmf_stepper_model.sv
// stepper motor with quadrature encoder, one encoder state per command pulse
// assumes registered pulse and direction from the axis; phases low at reset
`timescale 1ns/1ps
module cmf_stepper_model (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic pulse_i,
  input  wire logic dir_i,
  input  wire logic stall_i,
  input  wire logic glitch_i,
  output logic      phase_a_o,
  output logic      phase_b_o
);
  logic [1:0] step_r;
  logic       flip_r;
  // a stalled rotor loses steps; glitch flips both phases in one instant
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      step_r <= 2'h0;
      flip_r <= 1'b0;
    end else begin
      if (pulse_i && !stall_i) step_r <= dir_i ? step_r - 2'h1 : step_r + 2'h1;
      if (glitch_i) flip_r <= ~flip_r;
    end
  end
  // gray code: phase a leads on positive steps
  assign phase_a_o = step_r[1] ^ step_r[0] ^ flip_r;
  assign phase_b_o = step_r[1] ^ flip_r;
endmodule

// File: testbench/test_comparator_motion_functions.sv
// testbench: register-level tests of cmf_axis driving a stepper model
// assumes one 25 MHz clock and the word map of cmf_pkg
`timescale 1ns/1ps
module test_comparator_motion_functions;
  import cmf_pkg::*;
  logic        clk_sys_i, rst_n_i, avs_read_i, avs_write_i, stall, glitch;
  logic [7:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, d, p0;
  logic        avs_waitrequest_o, pulse_o, dir_o, busy_o, int_n_o;
  logic        phase_a, phase_b;
  int          n_mismatch, comparisons, gap_cnt, last_gap;
  logic [31:0] fb_tab [5] = '{32'h0, 32'h0010_0000, 32'h0020_0000, 32'h0030_0000,
                              32'h0060_0000};
  logic [31:0] df_tab [5] = '{32'h6, 32'h4, 32'h0, 32'h8, 32'h10};
  cmf_axis u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .encoder_phase_a_i(phase_a), .encoder_phase_b_i(phase_b), .pulse_o(pulse_o),
    .dir_o(dir_o), .busy_o(busy_o), .int_n_o(int_n_o));
  cmf_stepper_model u_motor (.clk_i(clk_sys_i), .rst_n_i(rst_n_i), .pulse_i(pulse_o),
    .dir_i(dir_o), .stall_i(stall), .glitch_i(glitch), .phase_a_o(phase_a),
    .phase_b_o(phase_b));
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  // spacing of the last two pulses shows the running period
  always @(posedge clk_sys_i) begin
    gap_cnt <= pulse_o ? 1 : gap_cnt + 1;
    if (pulse_o) last_gap <= gap_cnt;
  end
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one bus cycle, held until waitrequest is sampled low
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rdat);
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_write_i <= w;
    avs_read_i <= ~w;
    do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
    rdat = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    xfer(1'b1, a, wd, x);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, d);
    chk(d, exp);
  endtask
  // idle means twenty quiet cycles in a row, so chained operations finish
  task automatic go(input logic [31:0] op, input logic [8:0] cmd);
    int n;
    wr(OFS_OPDATA, op);
    wr(OFS_CMD, {23'h0, cmd});
    n = 0;
    while (n < 20) begin
      @(posedge clk_sys_i);
      n = (busy_o === 1'b0) ? n + 1 : 0;
    end
  endtask
  initial begin
    repeat (90000) @(posedge clk_sys_i);
    n_mismatch++;
    final_report;
  end
  initial begin
    rst_n_i = 1'b0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 8'h00;
    avs_writedata_i = 32'h0;
    stall = 1'b0;
    glitch = 1'b0;
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    chk_rd(OFS_ERRST, 32'h0);
    chk_rd(OFS_CMPCFG, 32'h0);
    chk_rd(8'h40, 32'h0);
    wr(OFS_FBCFG, 32'h0020_0000);
    wr(OFS_POSLIM, 32'h5);
    wr(OFS_NEGLIM, 32'hffff_fffb);
    // immediate stop both ways; start toward an active limit goes nowhere
    wr(OFS_CMPCFG, 32'h0000_3838);
    go(32'h0064_0004, {1'b0, CMD_CS_START});
    chk_rd(OFS_CMDPOS, 32'h5);
    go(32'h0064_0004, {1'b0, CMD_HS_START});
    chk_rd(OFS_CMDPOS, 32'h5);
    go(32'h0064_0004, {1'b1, CMD_CS_START});
    chk_rd(OFS_CMDPOS, 32'hffff_fffb);
    chk({31'h0, dir_o}, 32'h1);
    // decelerating action: high-speed start glides past, constant-speed stops dead
    wr(OFS_CMPCFG, 32'h0000_5858);
    go(32'h0064_0004, {1'b0, CMD_HS_START2});
    xfer(1'b0, OFS_CMDPOS, 32'h0, d);
    chk({31'h0, d > 32'h6 && d < 32'h64}, 32'h1);
    go(32'h0064_0004, {1'b1, CMD_CS_START2});
    chk_rd(OFS_CMDPOS, 32'hffff_fffb);
    // stalled rotor: deflection passes the maximum of 3
    wr(OFS_CMPCFG, 32'h0022_0000);
    wr(OFS_MAXDEF, 32'h3);
    wr(OFS_CMD, {24'h0, CMD_DEFL_CLR});
    chk_rd(OFS_DEFL, 32'h0);
    xfer(1'b0, OFS_EVTST, 32'h0, d);
    wr(OFS_EVTEN, 32'h0000_0400);
    stall <= 1'b1;
    go(32'h0064_0004, {1'b0, CMD_CS_START});
    chk_rd(OFS_DEFL, 32'h4);
    chk_rd(OFS_CMDPOS, 32'hffff_ffff);
    chk({31'h0, int_n_o}, 32'h0);
    xfer(1'b0, OFS_EVTST, 32'h0, d);
    chk({31'h0, d[EVT_C3_BIT]}, 32'h1);
    chk({31'h0, int_n_o}, 32'h1);
    wr(OFS_CMD, {24'h0, CMD_DEFL_CLR});
    chk_rd(OFS_DEFL, 32'h0);
    stall <= 1'b0;
    // every encoder mode and the swapped direction, eight pulses each
    wr(OFS_CMPCFG, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_FBCFG, fb_tab[i]);
      wr(OFS_CMD, {24'h0, CMD_DEFL_CLR});
      go(32'h0008_0004, {1'b0, CMD_CS_START});
      chk_rd(OFS_DEFL, df_tab[i]);
    end
    // speed change at comparator 5, position 39 plus 5
    wr(OFS_FBCFG, 32'h0020_0000);
    wr(OFS_CMP5CFG, {30'h0, ACT_SPEED});
    wr(OFS_CMP5, 32'h0000_002c);
    wr(OFS_PREDATA, 32'h0014_0004);
    wr(OFS_CMD, {24'h0, CMD_PRE_SPEED});
    xfer(1'b0, OFS_MSTAT, 32'h0, d);
    chk({31'h0, d[6]}, 32'h1);
    xfer(1'b0, OFS_EVTST, 32'h0, d);
    go(32'h0014_0008, {1'b0, CMD_CS_START});
    chk(32'(last_gap), 32'h4);
    xfer(1'b0, OFS_EVTST, 32'h0, d);
    chk({31'h0, d[EVT_C5_BIT]}, 32'h1);
    // leftover speed data is dropped, a queued next op still runs
    xfer(1'b0, OFS_CMDPOS, 32'h0, p0);
    wr(OFS_CMP5, 32'h0000_8000);
    repeat (2) begin
      wr(OFS_PREDATA, 32'h0014_0006);
      wr(OFS_CMD, {24'h0, CMD_PRE_SPEED});
    end
    go(32'h0004_0004, {1'b0, CMD_CS_START});
    chk_rd(OFS_CMDPOS, p0 + 32'h4);
    wr(OFS_PREDATA, 32'h0014_0006);
    wr(OFS_CMD, {24'h0, CMD_PRE_SPEED});
    wr(OFS_PREDATA, 32'h0003_0004);
    wr(OFS_CMD, {24'h0, CMD_PRE_NEXT});
    go(32'h0004_0004, {1'b0, CMD_CS_START});
    chk_rd(OFS_CMDPOS, p0 + 32'hb);
    // both phases flip in one instant
    glitch <= 1'b1;
    @(posedge clk_sys_i);
    glitch <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    chk({31'h0, int_n_o}, 32'h0);
    chk_rd(OFS_ERRST, 32'h0001_0000);
    chk_rd(OFS_ERRST, 32'h0);
    repeat (2) @(posedge clk_sys_i);
    chk({31'h0, int_n_o}, 32'h1);
    final_report;
  end
endmodule
bind cmf_axis cmf_axis_asserts u_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .encoder_phase_a_i(encoder_phase_a_i),
  .encoder_phase_b_i(encoder_phase_b_i), .pulse_o(pulse_o), .dir_o(dir_o),
  .busy_o(busy_o), .int_n_o(int_n_o));
